// file: hdl/adc_ctrl_pkg.sv
// Package with register map, fields, resets and timing counts of the converter control.
package adc_ctrl_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL1  = 8'h00;
    localparam logic [7:0] OFF_CTRL2  = 8'h04;
    localparam logic [7:0] OFF_RESULT = 8'h08;
    localparam logic [7:0] OFF_CMPVAL = 8'h0c;
    localparam logic [7:0] OFF_CFG    = 8'h10;
    // Channel codes.
    localparam logic [4:0] CH_TEMP    = 5'h1a;
    localparam logic [4:0] CH_BANDGAP = 5'h1b;
    localparam logic [4:0] CH_REFH    = 5'h1d;
    localparam logic [4:0] CH_REFL    = 5'h1e;
    localparam logic [4:0] CH_OFF     = 5'h1f;
    // Field positions.
    localparam int CTRL1_CONT = 5;
    localparam int CTRL1_IEN  = 6;
    localparam int CTRL1_DONE = 7;
    localparam int CTRL2_HW   = 0;
    localparam int CTRL2_CMP  = 1;
    localparam int CTRL2_GE   = 2;
    localparam int CTRL2_ACT  = 7;
    localparam int CFG_DIV    = 2;
    localparam int CFG_MODE   = 4;
    localparam int CFG_LONG   = 6;
    // Reset values.
    localparam logic [7:0] CTRL1_RST = 8'h1f;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [6:0] CFG_RST   = 7'h00;
    // Clock sources and result modes.
    localparam logic [1:0] SRC_BUS  = 2'h0;
    localparam logic [1:0] SRC_HALF = 2'h1;
    localparam logic [1:0] SRC_LOC  = 2'h2;
    localparam logic [1:0] SRC_ALT  = 2'h3;
    localparam logic [1:0] MODE_8   = 2'h0;
    localparam logic [1:0] MODE_12  = 2'h1;
    localparam logic [1:0] MODE_10  = 2'h2;
    // Timing counts in conversion clock ticks and bus cycles, bus response codes and converter states.
    localparam logic [4:0] SAMPLE_SHORT = 5'h04;
    localparam logic [4:0] SAMPLE_LONG  = 5'h14;
    localparam logic [1:0] SETTLE       = 2'h3;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_WAIT   = 2'b01,
        ST_SAMPLE = 2'b10,
        ST_CONV   = 2'b11
    } conv_state_e;
endpackage

// file: hdl/adc_ctrl.sv
// Successive-approximation converter control with an AXI4-Lite register slave.
// Notes on behaviour
// - Five-bit channel code selects input, references, off.
// - Reserved codes still convert; value undefined.
// - Codes 11010/11011 route temperature and bandgap.
// - Four selectable conversion clock sources.
// - Alternate input is external reference clock.
// - Alternate clock keeps running in wait.
// - Alternate clock unusable in stop modes.
// - Counter overflow starts conversion when enabled.
// - Trigger works in run, wait, retaining stop.
// - Twelve-bit result, right-justified 12/10/8 bits.
// - Single or continuous; single returns idle, or to wait in trigger mode.
// - Completion flag with tied interrupt request.
// - Compare result less-than or greater-or-equal.
// - Keeps converting in wait and retaining stop.
// - No lowest-power stop behaviour needed.
// - Any CTRL1 write aborts; all but all-ones writes restart.
// - Flag gated by compare; write/read clears.
// - All-ones channel stops without extra conversion.
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl #(
    parameter int AW = 8
) (
    // Clock, reset, enable.
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          ce,
    // AXI4-Lite slave.
    input  wire logic [AW-1:0] awaddr,
    input  wire logic          awvalid,
    output logic               awready_ff,
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    input  wire logic          wvalid,
    output logic               wready_ff,
    output logic [1:0]         bresp_ff,
    output logic               bvalid_ff,
    input  wire logic          bready,
    input  wire logic [AW-1:0] araddr,
    input  wire logic          arvalid,
    output logic               arready_ff,
    output logic [31:0]        rdata_ff,
    output logic [1:0]         rresp_ff,
    output logic               rvalid_ff,
    input  wire logic          rready,
    // Clock sources, trigger and power modes from outside.
    input  wire logic          local_async_conv_clock,
    input  wire logic          ext_reference_clock,
    input  wire logic          hw_conversion_trigger,
    input  wire logic          wait_mode,
    input  wire logic          retaining_stop_mode,
    // Analog front end.
    input  wire logic          cmp_in,
    output logic [4:0]         analog_chan_ff,
    output logic               temp_sensor_en_ff,
    output logic               bandgap_en_ff,
    output logic               sample_en_ff,
    output logic               converter_on_ff,
    output logic [11:0]        dac_code_ff,
    output logic               conv_irq_ff
);
    ////////////////////////////////////////////////////////////////////////////
    // Byte-lane merge used by all register writes.
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Right-justifies the raw code to the selected width.
    function automatic logic [11:0] fmt(input logic [11:0] c, input logic [1:0] m);
        if (m == adc_ctrl_pkg::MODE_12) begin
            return c;
        end else if (m == adc_ctrl_pkg::MODE_10) begin
            return {2'h0, c[11:2]};
        end
        return {4'h0, c[11:4]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake state.
    logic [AW-1:0] awaddr_ff, nxt_awaddr;
    logic [31:0]   wdata_ff, nxt_wdata;
    logic [3:0]    wstrb_ff, nxt_wstrb;
    logic          aw_full_ff, nxt_aw_full, w_full_ff, nxt_w_full;
    logic          nxt_awready, nxt_wready, nxt_bvalid, nxt_arready, nxt_rvalid;
    logic [1:0]    nxt_bresp, nxt_rresp;
    logic [31:0]   nxt_rdata;
    logic          do_wr, ar_take, wr_ctrl1, rd_result;
    // Registers and converter state.
    logic [7:0]    ctrl1_ff, nxt_ctrl1;
    logic [2:0]    ctrl2_ff, nxt_ctrl2;
    logic [6:0]    cfg_ff, nxt_cfg;
    logic [11:0]   cmpv_ff, nxt_cmpv, result_ff, nxt_result, nxt_dac, code;
    logic          done_ff, nxt_done;
    adc_ctrl_pkg::conv_state_e state_ff, nxt_state;
    logic [4:0]    cnt_ff, nxt_cnt;
    logic [3:0]    bit_ff, nxt_bit;
    logic [1:0]    settle_ff, nxt_settle;
    logic [2:0]    div_ff, nxt_div, mask;
    logic          half_ff, running, src_tick, conv_tick, hw_evt, finish, hit, set_done;
    logic [2:0]    lc_s, alt_s, trg_s;
    logic [1:0]    stop_s, cmp_s;
    logic [31:0]   wr_val;
    // Field positions used below, taken from the package.
    localparam int CFG_DIV_HI = adc_ctrl_pkg::CFG_DIV + 1;
    localparam int CTRL1_CONT = adc_ctrl_pkg::CTRL1_CONT;
    localparam int CTRL2_GE   = adc_ctrl_pkg::CTRL2_GE;
    localparam int CTRL2_HW   = adc_ctrl_pkg::CTRL2_HW;
    localparam int CTRL2_CMP  = adc_ctrl_pkg::CTRL2_CMP;
    localparam int CFG_LONG   = adc_ctrl_pkg::CFG_LONG;

    ////////////////////////////////////////////////////////////////////////////
    // Write address and data are held until both have arrived, in either order.
    always_comb begin
        nxt_awaddr  = (awvalid && awready_ff) ? awaddr : awaddr_ff;
        nxt_wdata   = (wvalid && wready_ff) ? wdata : wdata_ff;
        nxt_wstrb   = (wvalid && wready_ff) ? wstrb : wstrb_ff;
        do_wr       = aw_full_ff && w_full_ff && !bvalid_ff;
        nxt_aw_full = !do_wr && (aw_full_ff || (awvalid && awready_ff));
        nxt_w_full  = !do_wr && (w_full_ff || (wvalid && wready_ff));
        nxt_awready = !nxt_aw_full;
        nxt_wready  = !nxt_w_full;
        nxt_bvalid  = do_wr || (bvalid_ff && !bready);
        nxt_bresp   = bresp_ff;
        if (do_wr) begin
            nxt_bresp = (awaddr_ff > adc_ctrl_pkg::OFF_CFG || awaddr_ff[1:0] != 2'h0) ?
                        adc_ctrl_pkg::RESP_SLVERR : adc_ctrl_pkg::RESP_OKAY;
        end
        ar_take     = arvalid && arready_ff;
        nxt_arready = ar_take ? 1'b0 : (rvalid_ff && rready) ? 1'b1 : arready_ff;
        nxt_rvalid  = ar_take || (rvalid_ff && !rready);
        nxt_rdata   = rdata_ff;
        nxt_rresp   = rresp_ff;
        rd_result   = ar_take && araddr == adc_ctrl_pkg::OFF_RESULT;
        if (ar_take) begin
            nxt_rresp = adc_ctrl_pkg::RESP_OKAY;
            if (araddr == adc_ctrl_pkg::OFF_CTRL1) begin
                nxt_rdata = {24'h0, done_ff, ctrl1_ff[6:0]};
            end else if (araddr == adc_ctrl_pkg::OFF_CTRL2) begin
                nxt_rdata = {24'h0, running, 4'h0, ctrl2_ff};
            end else if (araddr == adc_ctrl_pkg::OFF_RESULT) begin
                nxt_rdata = {20'h0, result_ff};
            end else if (araddr == adc_ctrl_pkg::OFF_CMPVAL) begin
                nxt_rdata = {20'h0, cmpv_ff};
            end else if (araddr == adc_ctrl_pkg::OFF_CFG) begin
                nxt_rdata = {25'h0, cfg_ff};
            end else begin
                nxt_rdata = 32'h0;
                nxt_rresp = adc_ctrl_pkg::RESP_SLVERR;
            end
        end
    end

    // Registers the bus handshake.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_ff  <= '0;
            wdata_ff   <= 32'h0;
            wstrb_ff   <= 4'h0;
            aw_full_ff <= 1'b0;
            w_full_ff  <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= 2'h0;
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0;
            rresp_ff   <= 2'h0;
        end else if (ce) begin
            awaddr_ff  <= nxt_awaddr;
            wdata_ff   <= nxt_wdata;
            wstrb_ff   <= nxt_wstrb;
            aw_full_ff <= nxt_aw_full;
            w_full_ff  <= nxt_w_full;
            awready_ff <= nxt_awready;
            wready_ff  <= nxt_wready;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock source selection, division and gating of the conversion clock.
    always_comb begin
        running = state_ff[1];
        mask    = 3'((4'h1 << cfg_ff[CFG_DIV_HI -: 2]) - 4'h1);
        case (cfg_ff[1:0])
            adc_ctrl_pkg::SRC_BUS:  src_tick = 1'b1;
            adc_ctrl_pkg::SRC_HALF: src_tick = half_ff;
            adc_ctrl_pkg::SRC_LOC:  src_tick = lc_s[1] && !lc_s[2];
            default:                src_tick = alt_s[1] && !alt_s[2] && !stop_s[1];
        endcase
        conv_tick = running && src_tick && ((div_ff & mask) == mask);
        nxt_div   = !running ? 3'h0 : src_tick ? div_ff + 3'h1 : div_ff;
        hw_evt    = trg_s[1] && !trg_s[2];
    end
    ////////////////////////////////////////////////////////////////////////////
    // Register writes, start and stop control and the approximation sequence.
    always_comb begin
        wr_ctrl1   = do_wr && awaddr_ff == adc_ctrl_pkg::OFF_CTRL1;
        wr_val     = 32'h0;
        nxt_ctrl1  = ctrl1_ff;
        nxt_ctrl2  = ctrl2_ff;
        nxt_cfg    = cfg_ff;
        nxt_cmpv   = cmpv_ff;
        if (wr_ctrl1) begin
            wr_val    = merge({24'h0, ctrl1_ff}, wdata_ff, wstrb_ff);
            nxt_ctrl1 = wr_val[7:0];
        end else if (do_wr && awaddr_ff == adc_ctrl_pkg::OFF_CTRL2) begin
            wr_val    = merge({29'h0, ctrl2_ff}, wdata_ff, wstrb_ff);
            nxt_ctrl2 = wr_val[2:0];
        end else if (do_wr && awaddr_ff == adc_ctrl_pkg::OFF_CMPVAL) begin
            wr_val   = merge({20'h0, cmpv_ff}, wdata_ff, wstrb_ff);
            nxt_cmpv = wr_val[11:0];
        end else if (do_wr && awaddr_ff == adc_ctrl_pkg::OFF_CFG) begin
            wr_val  = merge({25'h0, cfg_ff}, wdata_ff, wstrb_ff);
            nxt_cfg = wr_val[6:0];
        end
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_bit    = bit_ff;
        nxt_settle = (settle_ff != 2'h0) ? settle_ff - 2'h1 : settle_ff;
        nxt_dac    = dac_code_ff;
        nxt_result = result_ff;
        finish     = 1'b0;
        code       = dac_code_ff;
        hit        = 1'b0;
        if (!cmp_s[1]) begin
            code[bit_ff] = 1'b0;
        end
        case (state_ff)
            adc_ctrl_pkg::ST_SAMPLE: begin
                if (conv_tick) begin
                    nxt_cnt = cnt_ff - 5'h1;
                    if (cnt_ff == 5'h1) begin
                        nxt_state  = adc_ctrl_pkg::ST_CONV;
                        nxt_bit    = 4'hb;
                        nxt_dac    = 12'h800;
                        nxt_settle = adc_ctrl_pkg::SETTLE;
                    end
                end
            end
            adc_ctrl_pkg::ST_CONV: begin
                if (conv_tick && settle_ff == 2'h0) begin
                    nxt_dac = code;
                    if (bit_ff == 4'h0) begin
                        finish     = 1'b1;
                        nxt_result = fmt(code, cfg_ff[5:4]);
                        hit        = ctrl2_ff[CTRL2_GE] ? nxt_result >= cmpv_ff
                                                        : nxt_result < cmpv_ff;
                        nxt_state  = ctrl1_ff[CTRL1_CONT] ? adc_ctrl_pkg::ST_SAMPLE :
                                     ctrl2_ff[CTRL2_HW] ? adc_ctrl_pkg::ST_WAIT :
                                     adc_ctrl_pkg::ST_IDLE;
                    end else begin
                        nxt_bit    = bit_ff - 4'h1;
                        nxt_dac[bit_ff - 4'h1] = 1'b1;
                        nxt_settle = adc_ctrl_pkg::SETTLE;
                    end
                end
            end
            adc_ctrl_pkg::ST_WAIT: begin
                if (hw_evt) begin
                    nxt_state = adc_ctrl_pkg::ST_SAMPLE;
                end
            end
            default: begin
                nxt_state = adc_ctrl_pkg::ST_IDLE;
            end
        endcase
        if (wr_ctrl1) begin
            if (nxt_ctrl1[4:0] == adc_ctrl_pkg::CH_OFF) begin
                nxt_state = adc_ctrl_pkg::ST_IDLE;
            end else if (nxt_ctrl2[CTRL2_HW]) begin
                nxt_state = adc_ctrl_pkg::ST_WAIT;
            end else begin
                nxt_state = adc_ctrl_pkg::ST_SAMPLE;
            end
        end
        if ((nxt_state == adc_ctrl_pkg::ST_SAMPLE && state_ff != adc_ctrl_pkg::ST_SAMPLE) ||
            wr_ctrl1 || finish) begin
            nxt_cnt = cfg_ff[CFG_LONG] ? adc_ctrl_pkg::SAMPLE_LONG : adc_ctrl_pkg::SAMPLE_SHORT;
        end
        set_done = finish && (!ctrl2_ff[CTRL2_CMP] || hit);
        nxt_done = set_done || (done_ff && !wr_ctrl1 && !rd_result);
    end
    // Registers control, synchronisers and outputs; the pins pass two flops first.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl1_ff  <= adc_ctrl_pkg::CTRL1_RST;
            ctrl2_ff  <= adc_ctrl_pkg::CTRL2_RST[2:0];
            cfg_ff    <= adc_ctrl_pkg::CFG_RST;
            cmpv_ff   <= 12'h000;
            result_ff <= 12'h000;
            done_ff   <= 1'b0;
            state_ff  <= adc_ctrl_pkg::ST_IDLE;
            cnt_ff    <= 5'h00;
            bit_ff    <= 4'h0;
            settle_ff <= 2'h0;
            div_ff    <= 3'h0;
            half_ff   <= 1'b0;
            lc_s      <= 3'h0;
            alt_s     <= 3'h0;
            trg_s     <= 3'h0;
            stop_s    <= 2'h0;
            cmp_s     <= 2'h0;
            dac_code_ff       <= 12'h000;
            analog_chan_ff    <= adc_ctrl_pkg::CH_OFF;
            temp_sensor_en_ff <= 1'b0;
            bandgap_en_ff     <= 1'b0;
            sample_en_ff      <= 1'b0;
            converter_on_ff   <= 1'b0;
            conv_irq_ff       <= 1'b0;
        end else if (ce) begin
            ctrl1_ff  <= nxt_ctrl1;
            ctrl2_ff  <= nxt_ctrl2;
            cfg_ff    <= nxt_cfg;
            cmpv_ff   <= nxt_cmpv;
            result_ff <= nxt_result;
            done_ff   <= nxt_done;
            state_ff  <= nxt_state;
            cnt_ff    <= nxt_cnt;
            bit_ff    <= nxt_bit;
            settle_ff <= nxt_settle;
            div_ff    <= nxt_div;
            half_ff   <= !half_ff;
            lc_s      <= {lc_s[1:0], local_async_conv_clock};
            alt_s     <= {alt_s[1:0], ext_reference_clock};
            trg_s     <= {trg_s[1:0], hw_conversion_trigger};
            stop_s    <= {stop_s[0], retaining_stop_mode};
            cmp_s     <= {cmp_s[0], cmp_in};
            dac_code_ff       <= nxt_dac;
            analog_chan_ff    <= nxt_ctrl1[4:0];
            temp_sensor_en_ff <= nxt_ctrl1[4:0] == adc_ctrl_pkg::CH_TEMP;
            bandgap_en_ff     <= nxt_ctrl1[4:0] == adc_ctrl_pkg::CH_BANDGAP;
            sample_en_ff      <= nxt_state == adc_ctrl_pkg::ST_SAMPLE;
            converter_on_ff   <= nxt_state[1];
            conv_irq_ff       <= nxt_done && nxt_ctrl1[adc_ctrl_pkg::CTRL1_IEN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the conversion control.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_start;
        ce && wr_ctrl1 && nxt_ctrl1[4:0] != adc_ctrl_pkg::CH_OFF && !nxt_ctrl2[CTRL2_HW];
    endsequence
    sequence s_sampling;
        state_ff == adc_ctrl_pkg::ST_SAMPLE && sample_en_ff && converter_on_ff;
    endsequence
    property p_sw_start;
        s_wr_start |=> s_sampling;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("write did not start");
    property p_off_idle;
        ce && wr_ctrl1 && nxt_ctrl1[4:0] == adc_ctrl_pkg::CH_OFF |=>
            state_ff == adc_ctrl_pkg::ST_IDLE && !converter_on_ff;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("all-ones kept running");
    property p_done_clr;
        ce && wr_ctrl1 && !set_done |=> !done_ff;
    endproperty
    a_done_clr: assert property (p_done_clr) else $error("flag not cleared");
    property p_irq;
        conv_irq_ff == (done_ff && ctrl1_ff[adc_ctrl_pkg::CTRL1_IEN]);
    endproperty
    a_irq: assert property (p_irq) else $error("irq not tied to flag");
    property p_single;
        ce && finish && !ctrl1_ff[CTRL1_CONT] && !ctrl2_ff[CTRL2_HW] && !wr_ctrl1 |=>
            state_ff == adc_ctrl_pkg::ST_IDLE;
    endproperty
    a_single: assert property (p_single) else $error("single did not idle");
    property p_hw;
        ce && state_ff == adc_ctrl_pkg::ST_WAIT && hw_evt && !wr_ctrl1 |=>
            state_ff == adc_ctrl_pkg::ST_SAMPLE;
    endproperty
    a_hw: assert property (p_hw) else $error("trigger ignored");
    property p_alt_stop;
        cfg_ff[1:0] == adc_ctrl_pkg::SRC_ALT && stop_s[1] |-> !conv_tick;
    endproperty
    a_alt_stop: assert property (p_alt_stop) else $error("alternate ran in stop");
    property p_fmt8;
        ce && finish && cfg_ff[5:4] == adc_ctrl_pkg::MODE_8 |=> result_ff[11:8] == 4'h0;
    endproperty
    a_fmt8: assert property (p_fmt8) else $error("8-bit not justified");
    property p_gate;
        !running |-> !conv_tick ##1 (div_ff == 3'h0 || !ce);
    endproperty
    a_gate: assert property (p_gate) else $error("clock not gated");
    property p_wait_run;
        running && wait_mode && src_tick && (div_ff & mask) == mask |-> conv_tick;
    endproperty
    a_wait_run: assert property (p_wait_run) else $error("wait stopped the clock");
endmodule
`default_nettype wire

// file: dv/analog_far_side.sv
// Far-side model of the analog inputs, the comparator and the clock pins.
`timescale 1ns/10ps
`default_nettype none
module analog_far_side (
    // Clock and applied voltage.
    input  wire logic        aclk,
    input  wire logic [11:0] vin,
    // Converter side.
    input  wire logic [11:0] dac_code_ff,
    input  wire logic        converter_on_ff,
    output logic             cmp_in,
    output logic             local_async_conv_clock,
    output logic             ext_reference_clock
);
    logic [3:0] div_ff = 4'h0;
    // Free-running divider that makes the two slow clock pins.
    always @(posedge aclk) div_ff <= div_ff + 4'h1;
    assign local_async_conv_clock = div_ff[1];
    assign ext_reference_clock    = div_ff[2];
    // Ideal comparator; while the converter is off it toggles, so no stale level helps.
    assign cmp_in = converter_on_ff ? (vin >= dac_code_ff) : div_ff[0];
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the converter control.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, cmp_in, conv_irq_ff;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata_ff, d, seed = 32'h31;
    logic [3:0]  wstrb = 4'hf;
    logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0]  bresp_ff, rresp_ff, r, m;
    logic        local_async_conv_clock, ext_reference_clock, temp_sensor_en_ff, bandgap_en_ff;
    logic        hw_conversion_trigger = 1'b0, wait_mode = 1'b0, retaining_stop_mode = 1'b0;
    logic        sample_en_ff, converter_on_ff;
    logic [4:0]  analog_chan_ff, ch;
    logic [11:0] dac_code_ff, vin = 12'h000;
    logic [4:0]  chs [7] = '{5'h00, 5'h1b, 5'h1a, 5'h0f, 5'h10, 5'h1d, 5'h1c};
    int          n_mismatch = 0, cmp_count = 0;

    adc_ctrl adc_ctrl_i (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready_ff, .wdata, .wstrb,
        .wvalid, .wready_ff, .bresp_ff, .bvalid_ff, .bready, .araddr, .arvalid, .arready_ff,
        .rdata_ff, .rresp_ff, .rvalid_ff, .rready, .local_async_conv_clock, .ext_reference_clock,
        .hw_conversion_trigger, .wait_mode, .retaining_stop_mode, .cmp_in, .analog_chan_ff,
        .temp_sensor_en_ff, .bandgap_en_ff, .sample_en_ff, .converter_on_ff, .dac_code_ff,
        .conv_irq_ff);
    analog_far_side analog_far_side_i (.aclk, .vin, .dac_code_ff, .converter_on_ff, .cmp_in,
        .local_async_conv_clock, .ext_reference_clock);

    // Bus clock of 100 ns.
    always #50 aclk = ~aclk;

    function automatic logic [11:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[11:0];
    endfunction

    // Reference model of the right-justified result.
    function automatic logic [31:0] fmt(input logic [11:0] v, input logic [1:0] md);
        return md == adc_ctrl_pkg::MODE_12 ? v : (md == adc_ctrl_pkg::MODE_10 ? v >> 2 : v >> 4);
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (e !== g) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // Write cycle: both channels offered together, each dropped when taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready_ff) awvalid <= 1'b0;
            if (wready_ff) wvalid <= 1'b0;
        end while ((awvalid && !awready_ff) || (wvalid && !wready_ff));
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid_ff);
        r = bresp_ff;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready_ff);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid_ff);
        d = rdata_ff;
        r = rresp_ff;
        rready <= 1'b0;
    endtask

    task automatic poll(input logic [7:0] a, input int b, input logic v);
        int k;
        k = 0;
        do begin
            rd(a);
            k++;
        end while (d[b] !== v && k < 2000);
        chk("poll", v, d[b]);
    endtask

    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog against a hung handshake or a conversion that never ends.
    initial begin
        repeat (90000) @(posedge aclk);
        n_mismatch++;
        complete_run();
    end

    // Main sequence.
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(adc_ctrl_pkg::OFF_CTRL1);
        chk("ctrl1_rst", 32'h1f, d);
        rd(adc_ctrl_pkg::OFF_CFG);
        chk("cfg_rst", 32'h0, d);
        rd(8'h20);
        chk("rd_unmapped", {30'h0, adc_ctrl_pkg::RESP_SLVERR}, {30'h0, r});
        chk("rd_unmapped_data", 32'h0, d);
        wr(8'h24, 32'h5);
        chk("wr_unmapped", {30'h0, adc_ctrl_pkg::RESP_SLVERR}, {30'h0, r});
        for (int i = 0; i < 7; i++) begin
            ch = chs[i];
            m = 2'(i % 3);
            vin <= rnd();
            wait_mode <= i[0];
            wr(adc_ctrl_pkg::OFF_CFG, {25'h0, ch == 5'h1a, m, ch == 5'h1a ? 2'h3 : 2'h0,
                2'(i)});
            wr(adc_ctrl_pkg::OFF_CTRL1, {25'h0, i[0], 1'b0, ch});
            poll(adc_ctrl_pkg::OFF_CTRL1, 7, 1'b1);
            chk("chan", ch, analog_chan_ff);
            chk("temp_en", ch == 5'h1a, temp_sensor_en_ff);
            chk("bg_en", ch == 5'h1b, bandgap_en_ff);
            chk("irq", i[0], conv_irq_ff);
            rd(adc_ctrl_pkg::OFF_RESULT);
            if (ch != 5'h1c) chk("result", fmt(vin, m), d);
            rd(adc_ctrl_pkg::OFF_CTRL1);
            chk("done_clr", 32'h0, d[7]);
            rd(adc_ctrl_pkg::OFF_CTRL2);
            chk("idle", 32'h0, d[7]);
        end
        // Compare true in the less-than sense and false in the greater-or-equal sense.
        wait_mode <= 1'b0;
        vin <= 12'h800;
        wr(adc_ctrl_pkg::OFF_CFG, 32'h10);
        wr(adc_ctrl_pkg::OFF_CMPVAL, 32'h900);
        for (int g = 0; g < 2; g++) begin
            wr(adc_ctrl_pkg::OFF_CTRL2, {29'h0, g[0], 2'h2});
            wr(adc_ctrl_pkg::OFF_CTRL1, 32'h0);
            poll(adc_ctrl_pkg::OFF_CTRL2, 7, 1'b0);
            rd(adc_ctrl_pkg::OFF_CTRL1);
            chk("cmp_done", g == 0, d[7]);
        end
        // Continuous run, then switched off by the all-ones channel.
        wr(adc_ctrl_pkg::OFF_CTRL2, 32'h0);
        wr(adc_ctrl_pkg::OFF_CTRL1, 32'h20);
        poll(adc_ctrl_pkg::OFF_CTRL1, 7, 1'b1);
        // A low clock enable must freeze the running approximation.
        ce <= 1'b0;
        @(posedge aclk);
        d = dac_code_ff;
        repeat (40) @(posedge aclk);
        chk("ce_hold", d, dac_code_ff);
        ce <= 1'b1;
        rd(adc_ctrl_pkg::OFF_RESULT);
        poll(adc_ctrl_pkg::OFF_CTRL1, 7, 1'b1);
        wr(adc_ctrl_pkg::OFF_CTRL1, 32'h1f);
        repeat (300) @(posedge aclk);
        chk("off", 32'h0, converter_on_ff);
        rd(adc_ctrl_pkg::OFF_CTRL1);
        chk("no_extra", 32'h0, d[7]);
        // Hardware trigger in the retaining stop mode.
        retaining_stop_mode <= 1'b1;
        wr(adc_ctrl_pkg::OFF_CTRL2, 32'h1);
        wr(adc_ctrl_pkg::OFF_CTRL1, 32'h0);
        repeat (300) @(posedge aclk);
        rd(adc_ctrl_pkg::OFF_CTRL1);
        chk("hw_wait", 32'h0, d[7]);
        hw_conversion_trigger <= 1'b1;
        repeat (20) @(posedge aclk);
        hw_conversion_trigger <= 1'b0;
        poll(adc_ctrl_pkg::OFF_CTRL1, 7, 1'b1);
        rd(adc_ctrl_pkg::OFF_RESULT);
        chk("hw_result", 32'h800, d);
        repeat (300) @(posedge aclk);
        rd(adc_ctrl_pkg::OFF_CTRL1);
        chk("one_event", 32'h0, d[7]);
        complete_run();
    end
endmodule
`default_nettype wire
